// File: uart_shadow_regs.svh
`ifndef UART_SHADOW_REGS_SVH
`define UART_SHADOW_REGS_SVH

// Data alias window: sixteen consecutive words, alias 9 at 0x50001054
`define SHADOW_BASE_ADDR   32'h50001030
`define SHADOW_DATA_9_ADDR 32'h50001054
`define SHADOW_SPAN        32'h00000040
`define SHADOW_RESET       16'h0000

// Control and status words
`define LINE_STATUS_ADDR   32'h50001014
`define FIFO_CONTROL_ADDR  32'h50001008
`define INT_STATUS_ADDR    32'h50001080
`define INT_MASK_ADDR      32'h50001084

// Line status fields
`define LS_DATA_READY_BIT  0
`define LS_OVERRUN_BIT     1
`define LS_TX_EMPTY_BIT    5
`define LS_TX_FULL_BIT     6

// FIFO control fields
`define FC_FIFO_EN_BIT     0
`define FC_IR_MODE_BIT     1

// Interrupt status and mask fields
`define INT_RX_BIT         0
`define INT_OVERRUN_BIT    1
`define INT_TX_EMPTY_BIT   2
`define INT_W              3
`define INT_MASK_RESET     3'h0

// Sizes
`define CHAR_W             8
`define FIFO_DEPTH_DEF     16

`endif

// File: uart_shadow_pkg.sv
package uart_shadow_pkg;
    `include "uart_shadow_regs.svh"

    typedef logic [`CHAR_W-1:0] char_t;
    typedef logic [`INT_W-1:0]  int_bits_t;
    typedef enum logic {LINE_UART, LINE_INFRARED} line_mode_t;
endpackage : uart_shadow_pkg

// File: fifo_mem_if.sv
`timescale 1ns/1ns
interface fifo_mem_if #(
    parameter int WIDTH = 8,
    parameter int AW    = 4
);
    logic             wr_en;
    logic [AW-1:0]    wr_addr;
    logic [WIDTH-1:0] wr_data;
    logic [AW-1:0]    rd_addr;
    logic [WIDTH-1:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : fifo_mem_if

// File: char_fifo_mem.sv
`timescale 1ns/1ns
module char_fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // Clock
    input wire logic   pclk,
    // Storage port
    fifo_mem_if.mem    port
);
    logic [WIDTH-1:0] cell_reg [DEPTH];
    logic [WIDTH-1:0] rd_data_reg;

    // Storage cells carry no reset; validity is tracked by the owner's count
    always_ff @(posedge pclk) begin
        if (port.wr_en) begin
            cell_reg[port.wr_addr] <= port.wr_data;
        end
    end

    // Write-through keeps the head word coherent with a push in the same cycle
    always_ff @(posedge pclk) begin
        if (port.wr_en && (port.wr_addr == port.rd_addr)) begin
            rd_data_reg <= port.wr_data;
        end else begin
            rd_data_reg <= cell_reg[port.rd_addr];
        end
    end

    assign port.rd_data = rd_data_reg;
endmodule : char_fifo_mem

// File: uart_shadow_data_port.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`include "uart_shadow_regs.svh"
// Summary of operation
// - The data alias answers at sixteen consecutive word addresses so bursts reach it.
// - A read returns the character taken from the plain serial input, or the infrared one.
// - Read data counts as valid only while the receive data-ready flag is set.
// - With FIFOs off, a new character overwrites an unread one and flags overrun.
// - With FIFOs on, a read returns the head entry of the receive FIFO.
// - A character arriving at a full receive FIFO is dropped, contents kept, overrun flagged.
// - A write loads a character for the plain serial output or the infrared output.
// - With FIFOs off, one write clears the transmit-holding-empty flag.
// - With FIFOs off, further writes before that flag returns overwrite the held character.
// - With FIFOs on, writes are accepted up to the FIFO depth before full is reported.
// - A write while the transmit FIFO is full is discarded without touching the FIFO.
module uart_shadow_data_port #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Receive characters from the deserialisers
    input  wire logic                  rx_uart_valid,
    input  wire uart_shadow_pkg::char_t rx_uart_data,
    input  wire logic                  rx_ir_valid,
    input  wire uart_shadow_pkg::char_t rx_ir_data,
    // Transmit characters to the serialisers
    output logic                       tx_uart_req,
    output logic                       tx_ir_req,
    output uart_shadow_pkg::char_t     tx_data,
    input  wire logic                  tx_ack,
    // Interrupt
    output logic                       irq
);
    import uart_shadow_pkg::*;

    localparam int            AW        = $clog2(FIFO_DEPTH);
    localparam logic [AW:0]   DEPTH_CNT = (AW + 1)'(FIFO_DEPTH);
    localparam logic [AW:0]   CNT_ONE   = (AW + 1)'(1);

    fifo_mem_if #(.WIDTH(`CHAR_W), .AW(AW)) rx_mem_bus ();
    fifo_mem_if #(.WIDTH(`CHAR_W), .AW(AW)) tx_mem_bus ();

    // Registers
    logic [31:0]   prdata_reg;
    logic          pready_reg;
    logic          pslverr_reg;
    logic          fifo_en_reg;
    line_mode_t    line_mode_reg;
    int_bits_t     int_status_reg;
    int_bits_t     int_mask_reg;
    logic          irq_reg;
    logic          overrun_reg;
    logic          tx_empty_prev_reg;
    char_t         rx_hold_reg;
    logic          rx_hold_full_reg;
    char_t         tx_hold_reg;
    logic          tx_hold_full_reg;
    logic [AW-1:0] rx_wr_ptr_reg;
    logic [AW-1:0] rx_rd_ptr_reg;
    logic [AW:0]   rx_count_reg;
    logic [AW-1:0] tx_wr_ptr_reg;
    logic [AW-1:0] tx_rd_ptr_reg;
    logic [AW:0]   tx_count_reg;
    logic          tx_uart_req_reg;
    logic          tx_ir_req_reg;
    char_t         tx_data_reg;

    // Bus decode
    wire logic [31:0] alias_off   = paddr - `SHADOW_BASE_ADDR;
    wire logic        hit_alias   = (alias_off < `SHADOW_SPAN) && (alias_off[1:0] == 2'b00);
    wire logic        hit_ls      = (paddr == `LINE_STATUS_ADDR);
    wire logic        hit_fc      = (paddr == `FIFO_CONTROL_ADDR);
    wire logic        hit_is      = (paddr == `INT_STATUS_ADDR);
    wire logic        hit_im      = (paddr == `INT_MASK_ADDR);
    wire logic        hit_any     = hit_alias | hit_ls | hit_fc | hit_is | hit_im;
    wire logic        access_one  = psel & penable & ~pready_reg;
    wire logic        done        = psel & penable & pready_reg;
    wire logic        rd_alias    = done & ~pwrite & hit_alias;
    wire logic        wr_alias    = done & pwrite & hit_alias;
    wire logic        rd_ls       = done & ~pwrite & hit_ls;
    wire logic        wr_fc       = done & pwrite & hit_fc;
    wire logic        wr_is       = done & pwrite & hit_is;
    wire logic        wr_im       = done & pwrite & hit_im;
    // Toggling the FIFO enable empties both paths, as the old contents lose their meaning
    wire logic        flush       = wr_fc & (pwdata[`FC_FIFO_EN_BIT] != fifo_en_reg);
    wire logic        ir_mode     = (line_mode_reg == LINE_INFRARED);

    // Receive selection and status
    wire logic  rx_in_valid = ir_mode ? rx_ir_valid : rx_uart_valid;
    wire char_t rx_in_data  = ir_mode ? rx_ir_data : rx_uart_data;
    wire logic  rx_nonempty = (rx_count_reg != '0);
    wire logic  data_ready  = fifo_en_reg ? rx_nonempty : rx_hold_full_reg;
    wire char_t rx_head     = fifo_en_reg ? rx_mem_bus.rd_data : rx_hold_reg;
    wire logic  rx_pop      = rd_alias & fifo_en_reg & rx_nonempty;
    // A pop in the same cycle frees the slot, so the arrival is not an overrun
    wire logic  rx_full     = (rx_count_reg == DEPTH_CNT) & ~rx_pop;
    wire logic  rx_push     = rx_in_valid & fifo_en_reg & ~rx_full & ~flush;
    wire logic  rx_drop     = rx_in_valid & fifo_en_reg & rx_full;
    wire logic  rx_clobber  = rx_in_valid & ~fifo_en_reg & rx_hold_full_reg & ~rd_alias;
    wire logic  overrun_evt = rx_drop | rx_clobber;
    wire logic  rx_arrive   = rx_push | (rx_in_valid & ~fifo_en_reg);

    // Transmit status and loading
    wire logic  tx_full     = (tx_count_reg == DEPTH_CNT);
    wire logic  tx_empty    = fifo_en_reg ? (tx_count_reg == '0) : ~tx_hold_full_reg;
    wire logic  tx_push     = wr_alias & fifo_en_reg & ~tx_full & ~flush;
    wire logic  tx_hold_wr  = wr_alias & ~fifo_en_reg & ~flush;
    wire logic  out_busy    = tx_uart_req_reg | tx_ir_req_reg;
    // Loading only when idle leaves a cycle for the registered head to follow a pop
    wire logic  tx_pop      = fifo_en_reg & ~out_busy & (tx_count_reg != '0) & ~flush;
    wire logic  tx_hold_ld  = ~fifo_en_reg & ~out_busy & tx_hold_full_reg & ~flush;
    wire char_t tx_next_chr = fifo_en_reg ? tx_mem_bus.rd_data : tx_hold_reg;
    wire logic  tx_load     = tx_pop | tx_hold_ld;

    // Read data selection
    wire logic [31:0] ls_word  = (32'(data_ready) << `LS_DATA_READY_BIT)
                               | (32'(overrun_reg) << `LS_OVERRUN_BIT)
                               | (32'(tx_empty) << `LS_TX_EMPTY_BIT)
                               | (32'(tx_full) << `LS_TX_FULL_BIT);
    wire logic [31:0] fc_word  = (32'(fifo_en_reg) << `FC_FIFO_EN_BIT)
                               | (32'(ir_mode) << `FC_IR_MODE_BIT);
    wire logic [31:0] rd_mux   = hit_alias ? 32'(rx_head) :
                                 hit_ls    ? ls_word :
                                 hit_fc    ? fc_word :
                                 hit_is    ? 32'(int_status_reg) :
                                 hit_im    ? 32'(int_mask_reg) : 32'h00000000;

    // Interrupt status: hardware set wins over a write-one clear
    wire int_bits_t int_events = (int_bits_t'(rx_arrive) << `INT_RX_BIT)
                               | (int_bits_t'(overrun_evt) << `INT_OVERRUN_BIT)
                               | (int_bits_t'(tx_empty & ~tx_empty_prev_reg) << `INT_TX_EMPTY_BIT);
    wire int_bits_t int_clear  = wr_is ? pwdata[`INT_W-1:0] : '0;
    wire int_bits_t int_next   = (int_status_reg & ~int_clear) | int_events;

    // Counts and overrun flag next values
    wire logic [AW:0] rx_count_next = rx_count_reg + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
    wire logic [AW:0] tx_count_next = tx_count_reg + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
    wire logic        overrun_next  = overrun_evt | (overrun_reg & ~rd_ls);

    // Storage ports
    assign rx_mem_bus.wr_en   = rx_push;
    assign rx_mem_bus.wr_addr = rx_wr_ptr_reg;
    assign rx_mem_bus.wr_data = rx_in_data;
    assign rx_mem_bus.rd_addr = rx_rd_ptr_reg;
    assign tx_mem_bus.wr_en   = tx_push;
    assign tx_mem_bus.wr_addr = tx_wr_ptr_reg;
    assign tx_mem_bus.wr_data = pwdata[`CHAR_W-1:0];
    assign tx_mem_bus.rd_addr = tx_rd_ptr_reg;

    char_fifo_mem #(.WIDTH(`CHAR_W), .DEPTH(FIFO_DEPTH), .AW(AW)) rx_store (
        .pclk (pclk),
        .port (rx_mem_bus)
    );

    char_fifo_mem #(.WIDTH(`CHAR_W), .DEPTH(FIFO_DEPTH), .AW(AW)) tx_store (
        .pclk (pclk),
        .port (tx_mem_bus)
    );

    // APB answer: one wait state so the registered FIFO head has settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else begin
            pready_reg  <= access_one;
            pslverr_reg <= access_one & ~hit_any;
            if (access_one) begin
                prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    // Software control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_en_reg   <= 1'b0;
            line_mode_reg <= LINE_UART;
            int_mask_reg  <= `INT_MASK_RESET;
        end else begin
            if (wr_fc) begin
                fifo_en_reg   <= pwdata[`FC_FIFO_EN_BIT];
                line_mode_reg <= pwdata[`FC_IR_MODE_BIT] ? LINE_INFRARED : LINE_UART;
            end
            if (wr_im) begin
                int_mask_reg <= pwdata[`INT_W-1:0];
            end
        end
    end

    // Status flags and interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_reg    <= '0;
            irq_reg           <= 1'b0;
            overrun_reg       <= 1'b0;
            tx_empty_prev_reg <= 1'b1;
        end else begin
            int_status_reg    <= int_next;
            irq_reg           <= |(int_next & int_mask_reg);
            overrun_reg       <= overrun_next;
            tx_empty_prev_reg <= tx_empty;
        end
    end

    // Receive holding register for FIFO-less operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hold_reg      <= '0;
            rx_hold_full_reg <= 1'b0;
        end else if (flush) begin
            rx_hold_full_reg <= 1'b0;
        end else if (rx_in_valid && !fifo_en_reg) begin
            rx_hold_reg      <= rx_in_data;
            rx_hold_full_reg <= 1'b1;
        end else if (rd_alias && !fifo_en_reg) begin
            rx_hold_full_reg <= 1'b0;
        end
    end

    // Receive FIFO pointers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_wr_ptr_reg <= '0;
            rx_rd_ptr_reg <= '0;
            rx_count_reg  <= '0;
        end else if (flush) begin
            rx_wr_ptr_reg <= '0;
            rx_rd_ptr_reg <= '0;
            rx_count_reg  <= '0;
        end else begin
            rx_wr_ptr_reg <= rx_wr_ptr_reg + AW'(rx_push);
            rx_rd_ptr_reg <= rx_rd_ptr_reg + AW'(rx_pop);
            rx_count_reg  <= rx_count_next;
        end
    end

    // Transmit holding register for FIFO-less operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_hold_reg      <= '0;
            tx_hold_full_reg <= 1'b0;
        end else if (flush) begin
            tx_hold_full_reg <= 1'b0;
        end else if (tx_hold_wr) begin
            tx_hold_reg      <= pwdata[`CHAR_W-1:0];
            tx_hold_full_reg <= 1'b1;
        end else if (tx_hold_ld) begin
            tx_hold_full_reg <= 1'b0;
        end
    end

    // Transmit FIFO pointers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_wr_ptr_reg <= '0;
            tx_rd_ptr_reg <= '0;
            tx_count_reg  <= '0;
        end else if (flush) begin
            tx_wr_ptr_reg <= '0;
            tx_rd_ptr_reg <= '0;
            tx_count_reg  <= '0;
        end else begin
            tx_wr_ptr_reg <= tx_wr_ptr_reg + AW'(tx_push);
            tx_rd_ptr_reg <= tx_rd_ptr_reg + AW'(tx_pop);
            tx_count_reg  <= tx_count_next;
        end
    end

    // Character handed to the serialiser; the mode is fixed at load time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_uart_req_reg <= 1'b0;
            tx_ir_req_reg   <= 1'b0;
            tx_data_reg     <= '0;
        end else if (tx_load) begin
            tx_data_reg     <= tx_next_chr;
            tx_uart_req_reg <= ~ir_mode;
            tx_ir_req_reg   <= ir_mode;
        end else if (tx_ack) begin
            tx_uart_req_reg <= 1'b0;
            tx_ir_req_reg   <= 1'b0;
        end
    end

    // Outputs straight from flip-flops
    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign tx_uart_req = tx_uart_req_reg;
    assign tx_ir_req   = tx_ir_req_reg;
    assign tx_data     = tx_data_reg;
    assign irq         = irq_reg;
endmodule : uart_shadow_data_port

// File: uart_shadow_data_port_monitor.sv
`timescale 1ns/1ns
`include "uart_shadow_regs.svh"
module uart_shadow_data_port_monitor (
    // Clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // Bus
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            paddr,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // Serialiser handshake
    input wire logic                   tx_uart_req,
    input wire logic                   tx_ir_req,
    input wire uart_shadow_pkg::char_t tx_data,
    input wire logic                   tx_ack
);
    import uart_shadow_pkg::*;
    // Wrapping subtraction keeps the window test to one compare
    wire alias_hit = ((paddr - `SHADOW_BASE_ADDR) < `SHADOW_SPAN) && (paddr[1:0] == 2'h0);
    wire tx_busy   = tx_uart_req | tx_ir_req;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_alias_mapped: assert property (pready && alias_hit |-> !pslverr)
        else $error("alias word answered with error");
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("answer not in second access cycle");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    chk_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_tx_hold: assert property (tx_busy && !tx_ack |=> tx_busy && $stable(tx_data))
        else $error("char request dropped before acknowledge");
    chk_tx_release: assert property (tx_busy && tx_ack |=> !tx_busy)
        else $error("request kept after acknowledge");
    chk_tx_one_line: assert property (!(tx_uart_req && tx_ir_req))
        else $error("both serial lines requested");
    // Char lands in the holding stage at the answer edge and reaches the serialiser one edge later
    chk_tx_after_write: assert property (pready && pwrite && alias_hit
        && !tx_busy |-> ##2 tx_busy)
        else $error("written char not handed on");
endmodule : uart_shadow_data_port_monitor
bind uart_shadow_data_port uart_shadow_data_port_monitor mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_uart_req(tx_uart_req), .tx_ir_req(tx_ir_req),
    .tx_data(tx_data), .tx_ack(tx_ack));

// File: serial_partner.sv
`timescale 1ns/1ns
module serial_partner (
    // Clock
    input wire logic                   pclk,
    // Received chars toward the block
    output logic                       rx_uart_valid,
    output uart_shadow_pkg::char_t     rx_uart_data,
    output logic                       rx_ir_valid,
    output uart_shadow_pkg::char_t     rx_ir_data,
    // Transmit handshake
    input wire logic                   tx_uart_req,
    input wire logic                   tx_ir_req,
    input wire uart_shadow_pkg::char_t tx_data,
    output logic                       tx_ack
);
    import uart_shadow_pkg::*;
    int         ack_delay = 2;
    int         wait_cnt  = 0;
    logic [8:0] tx_log[$];
    initial begin
        {rx_uart_valid, rx_ir_valid, tx_ack} = 3'h0;
        {rx_uart_data, rx_ir_data} = 16'h0;
    end
    // One pulse per char; idle data is scrambled so stale values never pass
    task automatic send(input logic ir, input char_t ch);
        @(posedge pclk);
        rx_ir_valid   <= ir;
        rx_uart_valid <= !ir;
        rx_ir_data    <= ch;
        rx_uart_data  <= ch;
        @(posedge pclk);
        {rx_uart_valid, rx_ir_valid} <= 2'h0;
        rx_ir_data   <= ~ch;
        rx_uart_data <= ~ch;
    endtask : send
    // Serialiser takes a char after a programmable stall, line flag logged on top
    always @(posedge pclk) begin
        tx_ack <= 1'h0;
        if ((tx_uart_req || tx_ir_req) && !tx_ack) begin
            if (wait_cnt >= ack_delay) begin
                tx_ack   <= 1'h1;
                wait_cnt <= 0;
                tx_log.push_back({tx_ir_req, tx_data});
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule : serial_partner

// File: uart_shadow_data_port_tb.sv
`timescale 1ns/1ns
`include "uart_shadow_regs.svh"
module uart_shadow_data_port_tb;
    import uart_shadow_pkg::*;
    localparam logic [31:0] LS = `LINE_STATUS_ADDR;
    localparam logic [31:0] FC = `FIFO_CONTROL_ADDR;
    localparam logic [31:0] AL = `SHADOW_DATA_9_ADDR;
    localparam logic [31:0] BA = `SHADOW_BASE_ADDR;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        rx_uart_valid, rx_ir_valid, tx_uart_req, tx_ir_req, tx_ack, irq;
    char_t       rx_uart_data, rx_ir_data, tx_data;
    int          num_errors = 0;
    int          num_checks = 0;
    // Small depth keeps fill and overflow cases short
    uart_shadow_data_port #(.FIFO_DEPTH(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_uart_valid(rx_uart_valid),
        .rx_uart_data(rx_uart_data), .rx_ir_valid(rx_ir_valid), .rx_ir_data(rx_ir_data),
        .tx_uart_req(tx_uart_req), .tx_ir_req(tx_ir_req), .tx_data(tx_data),
        .tx_ack(tx_ack), .irq(irq));
    serial_partner partner (.pclk(pclk), .rx_uart_valid(rx_uart_valid),
        .rx_uart_data(rx_uart_data), .rx_ir_valid(rx_ir_valid), .rx_ir_data(rx_ir_data),
        .tx_uart_req(tx_uart_req), .tx_ir_req(tx_ir_req), .tx_data(tx_data), .tx_ack(tx_ack));
    // Clock
    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check
    // One APB transfer; waits for pready without assuming the wait count
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) num_errors++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        check(n, e, rd);
    endtask : rdc
    // Bounded wait for the serialiser to log n chars
    task automatic wait_log(input int n);
        for (int i = 0; i < 2000 && partner.tx_log.size() < n; i++) @(posedge pclk);
    endtask : wait_log
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // Watchdog, well beyond the expected run
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        final_report();
    end
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        {paddr, pwdata} = 64'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        rdc("line status", LS, 32'h20);
        rdc("fifo control", FC, 32'h0);
        apb(1'h0, 32'h50001100, 32'h0);
        check("unmapped error", 32'h1, {31'h0, er});
        partner.send(1'h0, 8'hA5);
        rdc("line status", LS, 32'h21);
        rdc("alias data", AL, 32'hA5);
        rdc("line status", LS, 32'h20);
        partner.send(1'h0, 8'h11);
        partner.send(1'h0, 8'h22);
        rdc("line status", LS, 32'h23);
        rdc("alias data", BA, 32'h22);
        // Infrared line: plain line input must be ignored
        apb(1'h1, FC, 32'h2);
        partner.send(1'h1, 8'h3C);
        partner.send(1'h0, 8'h99);
        rdc("alias data", BA + 32'h3C, 32'h3C);
        apb(1'h1, AL, 32'h55);
        wait_log(1);
        check("serial char", 32'h155, 32'(partner.tx_log[0]));
        // Stalled serialiser, FIFOs off
        apb(1'h1, FC, 32'h0);
        partner.ack_delay = 40;
        apb(1'h1, AL, 32'h41);
        apb(1'h1, AL, 32'h42);
        rdc("line status", LS, 32'h00);
        apb(1'h1, AL, 32'h43);
        wait_log(3);
        check("serial char", 32'h41, 32'(partner.tx_log[1]));
        check("serial char", 32'h43, 32'(partner.tx_log[2]));
        // FIFO mode receive overflow and drain
        apb(1'h1, FC, 32'h1);
        for (int i = 1; i <= 5; i++) partner.send(1'h0, 8'(i));
        rdc("line status", LS, 32'h23);
        for (int i = 1; i <= 4; i++) rdc("fifo head", BA + 32'(4 * i), 32'(i));
        rdc("line status", LS, 32'h20);
        // FIFO mode transmit fill past depth
        partner.ack_delay = 60;
        for (int i = 0; i < 6; i++) apb(1'h1, AL, 32'h61 + 32'(i));
        rdc("line status", LS, 32'h40);
        wait_log(8);
        repeat (150) @(posedge pclk);
        check("serial count", 32'h8, 32'(partner.tx_log.size()));
        for (int i = 0; i < 5; i++)
            check("serial char", 32'h61 + 32'(i), 32'(partner.tx_log[3 + i]));
        // Interrupt raise, mask and clear
        partner.ack_delay = 2;
        apb(1'h1, `INT_STATUS_ADDR, 32'h7);
        partner.send(1'h0, 8'h77);
        rdc("int status", `INT_STATUS_ADDR, 32'h1);
        check("irq", 32'h0, {31'h0, irq});
        apb(1'h1, `INT_MASK_ADDR, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq", 32'h1, {31'h0, irq});
        apb(1'h1, `INT_STATUS_ADDR, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq", 32'h0, {31'h0, irq});
        final_report();
    end
endmodule : uart_shadow_data_port_tb
